/* hw/rtc_cal_pkg.sv */
// Constants, field layouts and carriers for the calendar alarm, event
// status and interrupt block of the real-time clock.
// Assumes the time counters and write protection sit in other blocks.
//
// Contract
// RL1 - An alarm setting write is dropped while the write lock is on.
// RL2 - Software clears a field's match, writes the value, then re-enables.
// RL3 - Month alarm in bits 20:16 joins the match while bit 23 is set.
// RL4 - Date alarm in bits 29:24 joins the match while bit 31 is set.
// RL5 - Status bit 0 reads one while the counters may be updated by software.
// RL6 - Status bit 1 sets on an enabled alarm match and stays until cleared.
// RL7 - Status bit 2 sets on each one-second tick and stays until cleared.
// RL8 - Status bit 3 latches the chosen minute, hour, midnight or noon event.
// RL9 - Status bit 4 latches the chosen week, month or year change.
// RL10 - Status bit 5 flags bad counters, now or since the last status read.
// RL11 - A one written to bit n of the clear register clears status flag n.
// RL12 - A one written to bit n of the enable register enables source n.
// RL13 - A one written to bit n of the disable register disables source n.
// RL14 - The mask view register shows one for each enabled interrupt source.
// RL15 - The interrupt output is high while any enabled status flag is set.
package rtc_cal_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] CAL_ALARM_ADDR  = 32'h400E1474;
  localparam logic [31:0] STATUS_ADDR     = 32'h400E1478;
  localparam logic [31:0] FLAG_CLEAR_ADDR = 32'h400E147C;
  localparam logic [31:0] IRQ_SET_ADDR    = 32'h400E1480;
  localparam logic [31:0] IRQ_CLEAR_ADDR  = 32'h400E1484;
  localparam logic [31:0] IRQ_MASK_ADDR   = 32'h400E1488;

  // ----------------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------------
  localparam int NUM_FLAGS   = 6;
  localparam int FLAG_GRANT  = 0;
  localparam int FLAG_ALARM  = 1;
  localparam int FLAG_TICK   = 2;
  localparam int FLAG_TIME   = 3;
  localparam int FLAG_CAL    = 4;
  localparam int FLAG_ERROR  = 5;

  // ----------------------------------------------------------------------
  // Calendar alarm field positions and reset values
  // ----------------------------------------------------------------------
  localparam int MONTH_LSB   = 16;
  localparam int MONTH_W     = 5;
  localparam int MONTH_EN    = 23;
  localparam int DATE_LSB    = 24;
  localparam int DATE_W      = 6;
  localparam int DATE_EN     = 31;
  localparam logic [31:0] CAL_ALARM_WMASK =
    (32'h1 << DATE_EN) | (((32'h1 << DATE_W) - 32'h1) << DATE_LSB) |
    (32'h1 << MONTH_EN) | (((32'h1 << MONTH_W) - 32'h1) << MONTH_LSB);
  localparam logic [31:0] CAL_ALARM_RESET = 32'h00000000;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 6'h00;
  localparam logic [NUM_FLAGS-1:0] MASK_RESET  = 6'h00;

  // ----------------------------------------------------------------------
  // Event choice encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] TIME_MINUTE   = 2'h0;
  localparam logic [1:0] TIME_HOUR     = 2'h1;
  localparam logic [1:0] TIME_MIDNIGHT = 2'h2;
  localparam logic [1:0] TIME_NOON     = 2'h3;
  localparam logic [1:0] CAL_WEEK      = 2'h0;
  localparam logic [1:0] CAL_MONTH     = 2'h1;
  localparam logic [1:0] CAL_YEAR      = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic             day_of_month_match_enable;
    logic             rsv_30;
    logic [DATE_W-1:0] date;
    logic             month_match_enable;
    logic [1:0]       rsv_22_21;
    logic [MONTH_W-1:0] month;
    logic [15:0]      rsv_low;
  } cal_alarm_t;

  // One-cycle pulses from the time counters, index = time choice code
  typedef struct packed {
    logic noon;
    logic midnight;
    logic hour_change;
    logic minute_change;
  } time_events_t;

  // One-cycle pulses from the date counters, index = calendar choice code
  typedef struct packed {
    logic year_change;
    logic month_change;
    logic week_change;
  } cal_events_t;

endpackage

/* hw/rtc_flag_bank.sv */
// Sticky event flags with per-bit set and clear.
// Assumes set and clear are one-cycle requests on the same clock.
`timescale 1ns/1ps
module rtc_flag_bank #(
  parameter int            WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clear_in,
  output logic      [WIDTH-1:0] flags_out
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // ----------------------------------------------------------------------
  // Next state: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------------
  assign flags_next = (flags_reg & ~clear_in) | set_in;
  assign flags_out  = flags_reg;

  // Flag storage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_reg <= RESET_VALUE;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule // rtc_flag_bank

/* hw/rtc_cal_alarm_irq.sv */
// Calendar alarm setting, event status flags and interrupt mask of the
// real-time clock, reached by software over APB.
// Assumes the counters, time alarm and write lock arrive from other blocks
// on the same clock, as levels or one-cycle pulses.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module rtc_cal_alarm_irq
  import rtc_cal_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [31:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Counters and neighbouring blocks
  input  wire logic [MONTH_W-1:0]  month_bcd_in,
  input  wire logic [DATE_W-1:0]   date_bcd_in,
  input  wire logic                time_alarm_match_in,
  input  wire logic                write_lock_enable_in,
  input  wire logic                update_grant_in,
  input  wire logic                tick_in,
  input  wire time_events_t        time_events_in,
  input  wire cal_events_t         cal_events_in,
  input  wire logic [1:0]          time_event_choice_in,
  input  wire logic [1:0]          calendar_event_choice_in,
  input  wire logic                counters_invalid_in,
  // Interrupt
  output logic                     irq_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Picks one of four event pulses by its choice code
  function automatic logic pick_event(input logic [3:0] events,
                                      input logic [1:0] choice);
    pick_event = events[choice];
  endfunction

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_access;
  logic hit_alarm;
  logic hit_status;
  logic hit_clear;
  logic hit_set;
  logic hit_unset;
  logic hit_mask;
  logic mapped;

  assign setup_phase  = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;
  assign wr_access    = access_phase & pwrite_in;
  assign rd_access    = access_phase & ~pwrite_in;
  assign hit_alarm    = (paddr_in == CAL_ALARM_ADDR);
  assign hit_status   = (paddr_in == STATUS_ADDR);
  assign hit_clear    = (paddr_in == FLAG_CLEAR_ADDR);
  assign hit_set      = (paddr_in == IRQ_SET_ADDR);
  assign hit_unset    = (paddr_in == IRQ_CLEAR_ADDR);
  assign hit_mask     = (paddr_in == IRQ_MASK_ADDR);
  assign mapped       = hit_alarm | hit_status | hit_clear |
                        hit_set | hit_unset | hit_mask;

  // Zero wait states; unmapped addresses answer with an error
  assign pready_out   = 1'b1;
  assign pslverr_out  = access_phase & ~mapped;

  // ----------------------------------------------------------------------
  // Calendar alarm setting
  // ----------------------------------------------------------------------
  logic [31:0] alarm_reg;
  logic [31:0] alarm_next;
  logic        alarm_write;
  cal_alarm_t  alarm_fields;

  assign alarm_write  = wr_access & hit_alarm & ~write_lock_enable_in; // RL1
  assign alarm_next   = alarm_write ? (pwdata_in & CAL_ALARM_WMASK)
                                    : alarm_reg;
  assign alarm_fields = cal_alarm_t'(alarm_reg);

  // Alarm register storage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      alarm_reg <= CAL_ALARM_RESET;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  // ----------------------------------------------------------------------
  // Alarm match: disabled fields count as matching
  // ----------------------------------------------------------------------
  logic month_ok;
  logic date_ok;
  logic alarm_match;
  logic alarm_match_reg;
  logic alarm_rise;

  assign month_ok    = ~alarm_fields.month_match_enable |
                       (alarm_fields.month == month_bcd_in); // RL3
  assign date_ok     = ~alarm_fields.day_of_month_match_enable |
                       (alarm_fields.date == date_bcd_in); // RL4
  assign alarm_match = time_alarm_match_in & month_ok & date_ok;
  assign alarm_rise  = alarm_match & ~alarm_match_reg; // RL6

  // Previous match level, so a lasting match sets the flag once
  // The time alarm match is a level that lasts; without the edge the flag
  // would come straight back after software clears it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      alarm_match_reg <= 1'b0;
    end else begin
      alarm_match_reg <= alarm_match;
    end
  end

  // ----------------------------------------------------------------------
  // Event status flags
  // ----------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clear;
  logic [NUM_FLAGS-1:0] sw_clear;
  logic [NUM_FLAGS-1:0] read_clear;
  logic [NUM_FLAGS-1:0] event_status_flags;
  logic                 time_event;
  logic                 cal_event;

  assign time_event = pick_event(time_events_in, time_event_choice_in); // RL8
  assign cal_event  = pick_event({1'b0, cal_events_in},
                                 calendar_event_choice_in); // RL9

  // Set sources in flag order
  assign flag_set[FLAG_GRANT] = update_grant_in; // RL5
  assign flag_set[FLAG_ALARM] = alarm_rise; // RL6
  assign flag_set[FLAG_TICK]  = tick_in; // RL7
  assign flag_set[FLAG_TIME]  = time_event; // RL8
  assign flag_set[FLAG_CAL]   = cal_event; // RL9
  assign flag_set[FLAG_ERROR] = counters_invalid_in; // RL10

  // Write-one clear, and a status read that retires a past error
  // While the counters are still bad the set wins over the read clear,
  // so the error flag keeps reporting a fault that has not gone away
  assign sw_clear   = (wr_access & hit_clear) ?
                      pwdata_in[NUM_FLAGS-1:0] : '0; // RL11
  assign read_clear = (rd_access & hit_status) ?
                      (NUM_FLAGS'(1) << FLAG_ERROR) : '0; // RL10
  assign flag_clear = sw_clear | read_clear;

  rtc_flag_bank #(
    .WIDTH       (NUM_FLAGS),
    .RESET_VALUE (FLAGS_RESET)
  ) flags_u (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .set_in    (flag_set),
    .clear_in  (flag_clear),
    .flags_out (event_status_flags)
  );

  // ----------------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] mask_reg;
  logic [NUM_FLAGS-1:0] mask_next;
  logic [NUM_FLAGS-1:0] mask_on;
  logic [NUM_FLAGS-1:0] mask_off;

  assign mask_on   = (wr_access & hit_set) ?
                     pwdata_in[NUM_FLAGS-1:0] : '0; // RL12
  assign mask_off  = (wr_access & hit_unset) ?
                     pwdata_in[NUM_FLAGS-1:0] : '0; // RL13
  assign mask_next = (mask_reg & ~mask_off) | mask_on;

  // Mask storage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mask_reg <= MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Level interrupt from enabled flags
  assign irq_out = |(event_status_flags & mask_reg); // RL15

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;

  assign rd_mux =
    hit_alarm  ? alarm_reg :
    hit_status ? {{(32-NUM_FLAGS){1'b0}}, event_status_flags} :
    hit_mask   ? {{(32-NUM_FLAGS){1'b0}}, mask_reg} : // RL14
    32'h00000000;

  // The mux is sampled in the setup cycle, so read data stand in a
  // register for the whole access cycle and no wait state is needed
  // Read data register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_phase & ~pwrite_in) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata_out = prdata_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_lock_blocks_write: assert property ( // RL1
    (wr_access && hit_alarm && write_lock_enable_in) |=> $stable(alarm_reg))
    else $error("locked alarm write took effect");

  a_open_write_lands: assert property ( // RL1
    (wr_access && hit_alarm && !write_lock_enable_in) |=>
      (alarm_reg == ($past(pwdata_in) & CAL_ALARM_WMASK)))
    else $error("alarm write did not land");

  a_month_gates_alarm: assert property ( // RL3
    $rose(event_status_flags[FLAG_ALARM]) |->
      (!$past(alarm_fields.month_match_enable) ||
       $past(alarm_fields.month) == $past(month_bcd_in)))
    else $error("alarm set with month mismatch");

  a_date_gates_alarm: assert property ( // RL4
    $rose(event_status_flags[FLAG_ALARM]) |->
      (!$past(alarm_fields.day_of_month_match_enable) ||
       $past(alarm_fields.date) == $past(date_bcd_in)))
    else $error("alarm set with date mismatch");

  a_grant_shows: assert property ( // RL5
    update_grant_in |=> event_status_flags[FLAG_GRANT])
    else $error("update grant not shown");

  a_alarm_sticks: assert property ( // RL6
    (event_status_flags[FLAG_ALARM] && !flag_clear[FLAG_ALARM]) |=>
      event_status_flags[FLAG_ALARM])
    else $error("alarm flag dropped without clear");

  a_tick_sets: assert property ( // RL7
    tick_in |=> event_status_flags[FLAG_TICK])
    else $error("tick flag not set");

  a_time_event_sets: assert property ( // RL8
    time_events_in[time_event_choice_in] |=> event_status_flags[FLAG_TIME])
    else $error("chosen time event not latched");

  a_cal_event_sets: assert property ( // RL9
    (calendar_event_choice_in != 2'h3 &&
     cal_events_in[calendar_event_choice_in]) |=>
      event_status_flags[FLAG_CAL])
    else $error("chosen calendar event not latched");

  a_error_holds: assert property ( // RL10
    counters_invalid_in[*2] |=> event_status_flags[FLAG_ERROR])
    else $error("error flag low while counters invalid");

  a_clear_works: assert property ( // RL11
    (wr_access && hit_clear && pwdata_in[FLAG_TICK] && !tick_in) |=>
      !event_status_flags[FLAG_TICK])
    else $error("tick flag survived clear");

  a_enable_sets_mask: assert property ( // RL12
    (wr_access && hit_set) |=>
      ((mask_reg & $past(pwdata_in[NUM_FLAGS-1:0])) ==
       $past(pwdata_in[NUM_FLAGS-1:0])))
    else $error("enable write did not set mask");

  a_disable_clears: assert property ( // RL13
    (wr_access && hit_unset && !hit_set) |=>
      ((mask_reg & $past(pwdata_in[NUM_FLAGS-1:0])) == '0))
    else $error("disable write did not clear mask");

  a_irq_level: assert property ( // RL15
    (flag_set[FLAG_TICK] && mask_next[FLAG_TICK]) |=> irq_out)
    else $error("interrupt low with enabled flag set");

  a_read_retires_error: assert property ( // RL10
    (rd_access && hit_status && !counters_invalid_in) |=>
      !event_status_flags[FLAG_ERROR])
    else $error("error flag survived status read");

  a_grant_clear_works: assert property ( // RL11
    (wr_access && hit_clear && pwdata_in[FLAG_GRANT] &&
     !update_grant_in) |=> !event_status_flags[FLAG_GRANT])
    else $error("grant flag survived clear");

  a_mask_view_reads: assert property ( // RL14
    (setup_phase && !pwrite_in && hit_mask) |=>
      (prdata_out == {{(32-NUM_FLAGS){1'b0}}, $past(mask_reg)}))
    else $error("mask view read wrong");

  a_mask_holds: assert property ( // RL14
    !(wr_access && (hit_set || hit_unset)) |=> $stable(mask_reg))
    else $error("mask changed without a write");

  a_status_reads: assert property ( // RL5
    (setup_phase && !pwrite_in && hit_status) |=>
      (prdata_out == {{(32-NUM_FLAGS){1'b0}}, $past(event_status_flags)}))
    else $error("status read wrong");

  a_time_only_chosen: assert property ( // RL8
    (!event_status_flags[FLAG_TIME] &&
     !time_events_in[time_event_choice_in]) |=>
      !event_status_flags[FLAG_TIME])
    else $error("time flag set by an unchosen event");

  a_cal_only_chosen: assert property ( // RL9
    (!event_status_flags[FLAG_CAL] &&
     (calendar_event_choice_in == 2'h3 ||
      !cal_events_in[calendar_event_choice_in])) |=>
      !event_status_flags[FLAG_CAL])
    else $error("calendar flag set by an unchosen event");

  // ----------------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------------
  c_time_event:   cover property ($rose(event_status_flags[FLAG_TIME]));
  c_alarm_fires:  cover property ($rose(event_status_flags[FLAG_ALARM]));
  c_irq_rises:    cover property ($rose(irq_out));
  c_locked_write: cover property (wr_access && hit_alarm &&
                                  write_lock_enable_in);
  c_error_read:   cover property (rd_access && hit_status &&
                                  event_status_flags[FLAG_ERROR]);

endmodule // rtc_cal_alarm_irq

/* tb/rtc_cal_alarm_irq_test.sv */
// Self-checking bench for the calendar alarm, status flags and interrupt
// mask block, driven as an APB master plus the neighbouring event inputs.
// Assumes zero-wait APB slave and one-cycle event pulses on clk_in.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end
module rtc_cal_alarm_irq_test;
  import rtc_cal_pkg::*;
  logic         clk_in, reset_in, psel, penable, pwrite;
  logic [31:0]  paddr, pwdata, prdata_out, rd;
  logic         pready_out, pslverr_out, irq_out, err;
  logic [4:0]   month_bcd;
  logic [5:0]   date_bcd;
  logic         match, lock, grant, tick, invalid;
  time_events_t tev;
  cal_events_t  cev;
  logic [1:0]   tsel, csel;
  int           err_count, samples_checked;

  rtc_cal_alarm_irq dut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .month_bcd_in(month_bcd),
    .date_bcd_in(date_bcd), .time_alarm_match_in(match),
    .write_lock_enable_in(lock), .update_grant_in(grant), .tick_in(tick),
    .time_events_in(tev), .cal_events_in(cev),
    .time_event_choice_in(tsel), .calendar_event_choice_in(csel),
    .counters_invalid_in(invalid), .irq_out(irq_out));

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    results();
  end

  // ----------------------------------------------------------------------
  // APB master tasks, entered just after a rising edge
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
        @(posedge clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a,
                       input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      `CHECK(nm, exp, rd)
    end
  endtask
  // Pulses event inputs for one cycle, then lets the flags land
  task automatic pulse(input logic [3:0] t, input logic [2:0] c,
                       input logic s);
    begin
      tev <= time_events_t'(t);
      cev <= cal_events_t'(c);
      tick <= s;
      @(posedge clk_in);
      tev <= '0;
      cev <= '0;
      tick <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task automatic results();
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    month_bcd = 5'h01;
    date_bcd = 6'h01;
    match = 1'b0;
    lock = 1'b0;
    grant = 1'b0;
    tick = 1'b0;
    invalid = 1'b0;
    tev = '0;
    cev = '0;
    tsel = 2'h0;
    csel = 2'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    // Reset values and field layout
    rdchk("alarm reset", CAL_ALARM_ADDR, 32'h00000000);
    rdchk("status reset", STATUS_ADDR, 32'h00000000);
    rdchk("mask reset", IRQ_MASK_ADDR, 32'h00000000);
    `CHECK("mapped err", 1'b0, err)
    `CHECK("irq reset", 1'b0, irq_out)
    wr(CAL_ALARM_ADDR, 32'hFFFFFFFF);
    rdchk("alarm fields", CAL_ALARM_ADDR, 32'hBF9F0000);
    lock <= 1'b1;
    wr(CAL_ALARM_ADDR, 32'h00000000);
    rdchk("alarm locked", CAL_ALARM_ADDR, 32'hBF9F0000);
    lock <= 1'b0;
    // Unmapped address answers with an error and no data
    apb(1'b0, 32'h400E1490, 32'h0);
    `CHECK("unmapped err", 1'b1, err)
    `CHECK("unmapped data", 32'h00000000, rd)
    `CHECK("ready", 1'b1, pready_out)
    // Alarm match: enables off, new values, enables on; date differs first
    wr(CAL_ALARM_ADDR, 32'h3F1F0000);
    wr(CAL_ALARM_ADDR, 32'h25120000);
    rdchk("alarm values", CAL_ALARM_ADDR, 32'h25120000);
    wr(CAL_ALARM_ADDR, 32'hA5920000);
    month_bcd <= 5'h12;
    date_bcd <= 6'h24;
    match <= 1'b1;
    repeat (3) @(posedge clk_in);
    match <= 1'b0;
    rdchk("alarm miss", STATUS_ADDR, 32'h00000000);
    date_bcd <= 6'h25;
    match <= 1'b1;
    repeat (3) @(posedge clk_in);
    match <= 1'b0;
    repeat (3) @(posedge clk_in);
    rdchk("alarm hit", STATUS_ADDR, 32'h00000002);
    wr(FLAG_CLEAR_ADDR, 32'h00000002);
    rdchk("alarm cleared", STATUS_ADDR, 32'h00000000);
    // Date excluded: any date matches once its enable is off
    wr(CAL_ALARM_ADDR, 32'h25920000);
    date_bcd <= 6'h01;
    match <= 1'b1;
    repeat (2) @(posedge clk_in);
    match <= 1'b0;
    rdchk("date excluded", STATUS_ADDR, 32'h00000002);
    wr(FLAG_CLEAR_ADDR, 32'h0000003D);
    rdchk("other clears", STATUS_ADDR, 32'h00000002);
    wr(FLAG_CLEAR_ADDR, 32'h00000002);
    // Month still enabled: a wrong month blocks the alarm
    month_bcd <= 5'h11;
    match <= 1'b1;
    repeat (2) @(posedge clk_in);
    match <= 1'b0;
    rdchk("month miss", STATUS_ADDR, 32'h00000000);
    // Tick flag is sticky over several ticks; zero clear has no effect
    pulse(4'h0, 3'h0, 1'b1);
    pulse(4'h0, 3'h0, 1'b1);
    wr(FLAG_CLEAR_ADDR, 32'h00000000);
    rdchk("tick sticky", STATUS_ADDR, 32'h00000004);
    // Mask set, clear and view, with the interrupt output
    wr(IRQ_SET_ADDR, 32'h0000003F);
    rdchk("mask all", IRQ_MASK_ADDR, 32'h0000003F);
    `CHECK("irq tick", 1'b1, irq_out)
    wr(IRQ_CLEAR_ADDR, 32'h00000004);
    rdchk("mask less tick", IRQ_MASK_ADDR, 32'h0000003B);
    `CHECK("irq masked", 1'b0, irq_out)
    wr(IRQ_SET_ADDR, 32'h00000004);
    wr(FLAG_CLEAR_ADDR, 32'h00000004);
    @(posedge clk_in);
    `CHECK("irq after clear", 1'b0, irq_out)
    // Every time event choice: chosen event latches, others do not
    for (int c = 0; c < 4; c++) begin
      tsel <= 2'(c);
      pulse(4'hF & ~(4'h1 << c), 3'h0, 1'b0);
      rdchk("time other", STATUS_ADDR, 32'h00000000);
      pulse(4'h1 << c, 3'h0, 1'b0);
      rdchk("time chosen", STATUS_ADDR, 32'h00000008);
      `CHECK("irq time", 1'b1, irq_out)
      wr(FLAG_CLEAR_ADDR, 32'h00000008);
    end
    // Every calendar event choice; code 3 chooses none
    for (int c = 0; c < 4; c++) begin
      csel <= 2'(c);
      pulse(4'h0, 3'h7 & ~(3'h1 << c), 1'b0);
      rdchk("cal other", STATUS_ADDR, 32'h00000000);
      pulse(4'h0, 3'h1 << c, 1'b0);
      rdchk("cal chosen", STATUS_ADDR, (c < 3) ? 32'h10 : 32'h0);
      wr(FLAG_CLEAR_ADDR, 32'h00000010);
    end
    // Update grant flag follows the stopped counters
    grant <= 1'b1;
    repeat (3) @(posedge clk_in);
    rdchk("grant set", STATUS_ADDR, 32'h00000001);
    grant <= 1'b0;
    @(posedge clk_in);
    wr(FLAG_CLEAR_ADDR, 32'h00000001);
    rdchk("grant clear", STATUS_ADDR, 32'h00000000);
    // Counter error: reported once after it goes away, then reads zero
    invalid <= 1'b1;
    repeat (2) @(posedge clk_in);
    invalid <= 1'b0;
    @(posedge clk_in);
    `CHECK("irq error", 1'b1, irq_out)
    rdchk("error since read", STATUS_ADDR, 32'h00000020);
    rdchk("error gone", STATUS_ADDR, 32'h00000000);
    invalid <= 1'b1;
    @(posedge clk_in);
    rdchk("error held", STATUS_ADDR, 32'h00000020);
    rdchk("error still", STATUS_ADDR, 32'h00000020);
    invalid <= 1'b0;
    @(posedge clk_in);
    wr(FLAG_CLEAR_ADDR, 32'h00000020);
    rdchk("error cleared", STATUS_ADDR, 32'h00000000);
    results();
  end
endmodule // rtc_cal_alarm_irq_test
